// ===== pkg/cmbl_pkg.sv
// ============================================================
// shared constants and types
package cmbl_pkg;
  // address field widths
  localparam int CMBL_CFG_W  = 3;
  localparam int CMBL_SEL_W  = 2;
  localparam int CMBL_SET_W  = 13;
  localparam int CMBL_TAG_W  = 12;
  localparam int CMBL_LINE_W = CMBL_CFG_W + CMBL_SET_W + CMBL_TAG_W;
  localparam int CMBL_ADDR_W = CMBL_LINE_W + CMBL_SEL_W;
  // field positions inside the packed address {tag, set, cfg, sel}
  localparam int CMBL_SEL_LSB = 0;
  localparam int CMBL_CFG_LSB = CMBL_SEL_LSB + CMBL_SEL_W;
  localparam int CMBL_SET_LSB = CMBL_CFG_LSB + CMBL_CFG_W;
  localparam int CMBL_TAG_LSB = CMBL_SET_LSB + CMBL_SET_W;
  // reset values
  localparam logic [CMBL_ADDR_W-1:0] CMBL_ADDR_RST = 30'h0;
  localparam logic                   CMBL_LOCK_RST = 1'b0;
  // clocks the lock stays up after the snoop window of an owned fill
  localparam int         CMBL_EM_HOLD_CLKS = 2;
  localparam logic [1:0] CMBL_EM_HOLD_LAST = 2'(CMBL_EM_HOLD_CLKS - 1);
  // cache line state of the current processor cycle
  typedef enum logic [1:0] {CMBL_LS_I, CMBL_LS_S, CMBL_LS_E, CMBL_LS_M} cmbl_line_state_t;
  // snoop address sampling modes
  typedef enum logic [1:0] {CMBL_SNP_SYNC, CMBL_SNP_CLOCKED, CMBL_SNP_STROBED} cmbl_snoop_mode_t;
  // lock request sequencer
  typedef enum logic [1:0] {CMBL_IDLE, CMBL_LOCKED, CMBL_EM_HOLD, CMBL_WAIT_UNLOCK} cmbl_lock_state_t;
endpackage

// ===== hdl/cmbl_addr_latch.sv
`timescale 1ns/100ps
// ============================================================
// controller-gated address output latch for one address portion
module cmbl_addr_latch
  import cmbl_pkg::*;
#(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // address from the cycle logic
  input  wire logic [W-1:0] d,
  // gating from the memory controller
  input  wire logic         latch_en,
  input  wire logic         out_en_n,
  // pin side
  output logic      [W-1:0] q,
  output logic              oe
);

  // follow the cycle address while open, hold it while closed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else if (latch_en) begin
      q <= d;
    end
  end

  // drive only while the controller enables the outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oe <= 1'b0;
    end else begin
      oe <= !out_en_n;
    end
  end

endmodule // cmbl_addr_latch

// ===== hdl/cmbl_snoop_sampler.sv
`timescale 1ns/100ps
// ============================================================
// snoop address capture in synchronous, clocked or strobed mode
module cmbl_snoop_sampler
  import cmbl_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  // snoop controls
  input  wire cmbl_snoop_mode_t       mode,
  input  wire logic                   strobe,
  input  wire logic                   snoop_clock,
  // address lines seen as inputs
  input  wire logic [CMBL_ADDR_W-1:0] addr_in,
  // captured snoop address
  output logic      [CMBL_ADDR_W-1:0] addr,
  output logic                        valid
);

  logic strobe_prev;
  logic sclk_prev;
  logic done;
  logic take;

  // edge history of the strobe and the snoop clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_prev <= 1'b0;
      sclk_prev   <= 1'b0;
    end else begin
      strobe_prev <= strobe;
      sclk_prev   <= snoop_clock;
    end
  end

  // first qualifying edge of each strobe assertion
  always_comb begin
    take = 1'b0;
    unique case (mode)
      CMBL_SNP_SYNC:    take = strobe && !done;
      CMBL_SNP_CLOCKED: take = strobe && snoop_clock && !sclk_prev && !done;
      CMBL_SNP_STROBED: take = strobe && !strobe_prev;
      default:          take = 1'b0;
    endcase
  end

  // one capture per strobe assertion, rearmed when it goes away
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done <= 1'b0;
    end else begin
      done <= strobe && (done || take);
    end
  end

  // address lines are ignored unless the strobe qualifies them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr  <= CMBL_ADDR_RST;
      valid <= 1'b0;
    end else begin
      valid <= take;
      if (take) begin
        addr <= addr_in;
      end
    end
  end

endmodule // cmbl_snoop_sampler

// ===== hdl/cmbl_lock_addr.sv
`timescale 1ns/100ps
// ============================================================
// Function
// RL1: lock request only for locked cycles reaching bus
// RL2: locked E/M hits give no lock request
// RL3: split lock from first to last strobe
// RL4: lock and split at processor strobe mean split
// RL5: split lock drops one clock after unlock
// RL6: processor leaves idle clock between locked operations
// RL7: invalid read lock ends two clocks after window
// RL8: shared read lock ends when processor unlocks
// RL9: write lock ends at later of unlock, write
// RL10: lock and address valid with cycle strobe
// RL11: address is cfg3, sel2, set13, tag12, bidirectional
// RL12: controller latch and output enables gate address
// RL13: open latches, enabled outputs drive with strobe
// RL14: closed latches keep previous address on pins
// RL15: disabled outputs float until enables assert
// RL16: address may change after next-address or done
// RL17: controller floats us and drives snoop address
// RL18: snoop capture per synchronous, clocked, strobed mode
// RL19: address sampled only with snoop strobe
// RL20: parity over all line address bits; code also folds in the sel bits
// RL21: lock request low from reset until qualified
module cmbl_lock_addr
  import cmbl_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  // processor cycle attributes
  input  wire logic                   cpu_addr_strobe,
  input  wire logic                   cpu_lock,
  input  wire logic                   cpu_split_cycle,
  input  wire logic                   cpu_write,
  input  wire cmbl_line_state_t       cpu_line_state,
  // controller core
  input  wire logic                   cache_lock_mode,
  input  wire logic                   bus_cycle_req,
  input  wire logic                   snoop_out_req,
  input  wire logic [CMBL_ADDR_W-1:0] cycle_addr,
  input  wire logic                   snoop_window_end,
  input  wire logic                   line_owned,
  // memory controller handshake
  input  wire logic                   next_addr_request,
  input  wire logic                   cycle_done,
  input  wire logic                   line_addr_latch_en,
  input  wire logic                   subline_addr_latch_en,
  input  wire logic                   line_addr_out_en_n,
  input  wire logic                   subline_addr_out_en_n,
  // snoop inputs
  input  wire cmbl_snoop_mode_t       snoop_mode,
  input  wire logic                   snoop_request_strobe,
  input  wire logic                   snoop_clock,
  // memory address pins
  input  wire logic [CMBL_CFG_W-1:0]  mem_cfg_addr_in,
  output logic      [CMBL_CFG_W-1:0]  mem_cfg_addr_out,
  output logic                        mem_cfg_addr_oe,
  input  wire logic [CMBL_SEL_W-1:0]  mem_sel_addr_in,
  output logic      [CMBL_SEL_W-1:0]  mem_sel_addr_out,
  output logic                        mem_sel_addr_oe,
  input  wire logic [CMBL_SET_W-1:0]  mem_set_addr_in,
  output logic      [CMBL_SET_W-1:0]  mem_set_addr_out,
  output logic                        mem_set_addr_oe,
  input  wire logic [CMBL_TAG_W-1:0]  mem_tag_addr_in,
  output logic      [CMBL_TAG_W-1:0]  mem_tag_addr_out,
  output logic                        mem_tag_addr_oe,
  // memory cycle outputs
  output logic                        mem_lock_request,
  output logic                        mem_cycle_addr_strobe,
  output logic                        snoop_cycle_strobe_out,
  output logic                        mem_addr_parity,
  output logic                        addr_may_change,
  // captured snoop address
  output logic      [CMBL_ADDR_W-1:0] snoop_addr,
  output logic                        snoop_addr_valid
);

  // ============================================================
  // cycle attribute tracking
  cmbl_lock_state_t       state;
  cmbl_lock_state_t       next_state;
  logic                   split_seen;
  cmbl_line_state_t       line_seen;
  logic                   write_seen;
  logic                   cur_split;
  cmbl_line_state_t       cur_line;
  logic                   cur_write;
  logic                   read_invalid;
  logic                   start_lock;
  logic                   next_lock;
  logic [1:0]             hold_cnt;
  logic [CMBL_ADDR_W-1:0] addr_cur;
  logic [CMBL_ADDR_W-1:0] next_addr;
  logic [CMBL_LINE_W-1:0] line_q;
  logic [CMBL_SEL_W-1:0]  sub_q;
  logic                   line_oe;
  logic                   sub_oe;
  logic [CMBL_LINE_W-1:0] next_line;
  logic [CMBL_SEL_W-1:0]  next_sub;

  // attributes of the processor cycle, caught at its strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      split_seen <= 1'b0;
      line_seen  <= CMBL_LS_I;
      write_seen <= 1'b0;
    end else if (cpu_addr_strobe) begin
      split_seen <= cpu_lock && cpu_split_cycle;
      line_seen  <= cpu_line_state;
      write_seen <= cpu_write;
    end
  end

  // attributes valid in the strobe cycle itself or held after it
  always_comb begin
    cur_split = cpu_addr_strobe ? (cpu_lock && cpu_split_cycle) : split_seen; // [RL4]
    cur_line  = cpu_addr_strobe ? cpu_line_state : line_seen;
    cur_write = cpu_addr_strobe ? cpu_write : write_seen;
  end

  // a locked cycle qualifies only when it opens a memory bus cycle
  assign start_lock = bus_cycle_req && cpu_lock && (cur_split || cache_lock_mode); // [RL1] [RL2]

  // ============================================================
  // lock request sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      CMBL_IDLE: begin
        if (start_lock) begin
          next_state = CMBL_LOCKED; // [RL3] [RL7] [RL8] [RL9]
        end
      end
      CMBL_LOCKED: begin
        if (read_invalid && !cur_split && snoop_window_end && line_owned) begin
          next_state = CMBL_EM_HOLD; // [RL7]
        end else if (!cpu_lock && !bus_cycle_req) begin
          // later of unlock and the last strobe, never in a strobe clock
          next_state = CMBL_IDLE; // [RL5] [RL8] [RL9]
        end
      end
      CMBL_EM_HOLD: begin
        if (hold_cnt == CMBL_EM_HOLD_LAST) begin
          next_state = CMBL_WAIT_UNLOCK; // [RL7]
        end
      end
      CMBL_WAIT_UNLOCK: begin
        // the owned line finishes the sequence inside the cache
        if (!cpu_lock) begin
          next_state = CMBL_IDLE; // [RL6]
        end
      end
    endcase
  end

  assign next_lock = (next_state == CMBL_LOCKED) || (next_state == CMBL_EM_HOLD);

  // sequencer state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= CMBL_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // remember that the sequence began with a read of an invalid line
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      read_invalid <= 1'b0;
    end else if (state == CMBL_IDLE && start_lock) begin
      read_invalid <= !cur_write && (cur_line == CMBL_LS_I); // [RL7]
    end
  end

  // clocks spent holding the lock after an owned fill
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_cnt <= 2'h0;
    end else begin
      hold_cnt <= (state == CMBL_EM_HOLD) ? hold_cnt + 2'h1 : 2'h0;
    end
  end

  // lock request, registered in step with the cycle strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_lock_request <= CMBL_LOCK_RST; // [RL21]
    end else begin
      mem_lock_request <= next_lock; // [RL10]
    end
  end

  // cycle strobes toward the memory bus
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_cycle_addr_strobe  <= 1'b0;
      snoop_cycle_strobe_out <= 1'b0;
    end else begin
      mem_cycle_addr_strobe  <= bus_cycle_req;
      snoop_cycle_strobe_out <= snoop_out_req && !bus_cycle_req;
    end
  end

  // ============================================================
  // address path
  assign next_addr = (bus_cycle_req || snoop_out_req) ? cycle_addr : addr_cur;

  // cycle address at the latch input, kept until the next strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_cur <= CMBL_ADDR_RST;
    end else begin
      addr_cur <= next_addr; // [RL16]
    end
  end

  // controller saw next-address or done: pins may change from now
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_may_change <= 1'b0;
    end else begin
      addr_may_change <= !(bus_cycle_req || snoop_out_req) &&
                         (addr_may_change || next_addr_request || cycle_done); // [RL16]
    end
  end

  // line portion: cfg, set and tag
  cmbl_addr_latch #(
    .W (CMBL_LINE_W)
  ) u_line_latch (
    .clk      (clk),
    .arst_n   (arst_n),
    .d        (next_addr[CMBL_ADDR_W-1:CMBL_CFG_LSB]),
    .latch_en (line_addr_latch_en),   // [RL12] [RL14]
    .out_en_n (line_addr_out_en_n),   // [RL12] [RL15] [RL17]
    .q        (line_q),
    .oe       (line_oe)
  );

  // sub-line portion: select
  cmbl_addr_latch #(
    .W (CMBL_SEL_W)
  ) u_sub_latch (
    .clk      (clk),
    .arst_n   (arst_n),
    .d        (next_addr[CMBL_CFG_LSB-1:CMBL_SEL_LSB]),
    .latch_en (subline_addr_latch_en), // [RL12] [RL14]
    .out_en_n (subline_addr_out_en_n), // [RL12] [RL15] [RL17]
    .q        (sub_q),
    .oe       (sub_oe)
  );

  // split the latched address onto the four bidirectional fields
  always_comb begin
    mem_cfg_addr_out = line_q[CMBL_SET_LSB-CMBL_CFG_LSB-1:0]; // [RL11] [RL13]
    mem_set_addr_out = line_q[CMBL_TAG_LSB-CMBL_CFG_LSB-1:CMBL_SET_LSB-CMBL_CFG_LSB];
    mem_tag_addr_out = line_q[CMBL_LINE_W-1:CMBL_TAG_LSB-CMBL_CFG_LSB];
    mem_sel_addr_out = sub_q;
    mem_cfg_addr_oe  = line_oe;
    mem_set_addr_oe  = line_oe;
    mem_tag_addr_oe  = line_oe;
    mem_sel_addr_oe  = sub_oe;
  end

  // what the latches will hold after this edge
  assign next_line = line_addr_latch_en ? next_addr[CMBL_ADDR_W-1:CMBL_CFG_LSB] : line_q;
  assign next_sub  = subline_addr_latch_en ? next_addr[CMBL_CFG_LSB-1:0] : sub_q;

  // parity follows the latched address so it matches the pins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_addr_parity <= 1'b0;
    end else begin
      mem_addr_parity <= ^{next_line, next_sub}; // [RL20]
    end
  end

  // ============================================================
  // snoop address capture
  cmbl_snoop_sampler u_snoop (
    .clk         (clk),
    .arst_n      (arst_n),
    .mode        (snoop_mode),
    .strobe      (snoop_request_strobe), // [RL19]
    .snoop_clock (snoop_clock),          // [RL18]
    .addr_in     ({mem_tag_addr_in, mem_set_addr_in, mem_cfg_addr_in,
                   mem_sel_addr_in}),    // [RL17]
    .addr        (snoop_addr),
    .valid       (snoop_addr_valid)
  );

  // ============================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_split_start;
    state == CMBL_IDLE && bus_cycle_req && cpu_addr_strobe && cpu_lock && cpu_split_cycle;
  endsequence
  sequence s_owned_fill;
    state == CMBL_LOCKED && read_invalid && !cur_split && snoop_window_end && line_owned;
  endsequence
  property p_split_start;
    s_split_start |=> mem_lock_request && mem_cycle_addr_strobe;
  endproperty
  a_split_start: assert property (p_split_start) // [RL4]
    else $error("split lock not raised with cycle strobe");
  property p_rise_with_strobe;
    $rose(mem_lock_request) |-> mem_cycle_addr_strobe;
  endproperty
  a_rise_with_strobe: assert property (p_rise_with_strobe) // [RL1]
    else $error("lock request rose without a cycle strobe");
  property p_no_bus_no_lock;
    state == CMBL_IDLE && !bus_cycle_req |=> !mem_lock_request;
  endproperty
  a_no_bus_no_lock: assert property (p_no_bus_no_lock) // [RL2]
    else $error("lock request without a memory bus cycle");
  property p_split_release;
    state == CMBL_LOCKED && !read_invalid && !cpu_lock && !bus_cycle_req |=> !mem_lock_request;
  endproperty
  a_split_release: assert property (p_split_release) // [RL5]
    else $error("lock request not released one clock after unlock");
  // a later cycle of a locked sequence must still carry the lock with its strobe
  property p_hold_past_strobe;
    state == CMBL_LOCKED && bus_cycle_req |=> mem_lock_request && mem_cycle_addr_strobe;
  endproperty
  a_hold_past_strobe: assert property (p_hold_past_strobe) // [RL3]
    else $error("lock request not held through the cycle strobe");
  property p_owned_fill;
    s_owned_fill |=> mem_lock_request ##1 mem_lock_request ##1 !mem_lock_request;
  endproperty
  a_owned_fill: assert property (p_owned_fill) // [RL7]
    else $error("owned fill lock not ended two clocks after window");
  property p_drive_open;
    bus_cycle_req && line_addr_latch_en && !line_addr_out_en_n
      |=> mem_set_addr_oe && mem_cycle_addr_strobe &&
          mem_set_addr_out == $past(cycle_addr[CMBL_TAG_LSB-1:CMBL_SET_LSB]);
  endproperty
  a_drive_open: assert property (p_drive_open) // [RL13]
    else $error("address not driven with the cycle strobe");
  property p_closed_hold;
    !line_addr_latch_en |=> $stable(mem_tag_addr_out) && $stable(mem_cfg_addr_out);
  endproperty
  a_closed_hold: assert property (p_closed_hold) // [RL14]
    else $error("closed latch changed the address pins");
  property p_float;
    line_addr_out_en_n && subline_addr_out_en_n |=> !mem_tag_addr_oe && !mem_sel_addr_oe;
  endproperty
  a_float: assert property (p_float) // [RL15]
    else $error("address driven while output enables inactive");
  property p_parity;
    mem_addr_parity == ^{mem_tag_addr_out, mem_set_addr_out, mem_cfg_addr_out, mem_sel_addr_out};
  endproperty
  a_parity: assert property (p_parity) // [RL20]
    else $error("address parity does not match the latched address");
  property p_snoop_sync;
    snoop_mode == CMBL_SNP_SYNC && $rose(snoop_request_strobe)
      |=> snoop_addr_valid && snoop_addr == $past({mem_tag_addr_in, mem_set_addr_in,
                                                   mem_cfg_addr_in, mem_sel_addr_in});
  endproperty
  a_snoop_sync: assert property (p_snoop_sync) // [RL18]
    else $error("synchronous snoop address not captured");
  property p_snoop_only_strobe;
    !snoop_request_strobe |=> !snoop_addr_valid;
  endproperty
  a_snoop_only_strobe: assert property (p_snoop_only_strobe) // [RL19]
    else $error("snoop address sampled without the strobe");

endmodule // cmbl_lock_addr

// ===== sim/cmbl_mbc_model.sv
`timescale 1ns/100ps
// ============================================================
// memory bus controller model: gating, handshake, snoop driver
module cmbl_mbc_model
  import cmbl_pkg::*;
(
  // clock, reset and test controls
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   hold_latch,
  input  wire logic                   float_out,
  input  wire logic                   slow,
  input  wire logic                   snoop_req,
  input  wire logic [CMBL_ADDR_W-1:0] snoop_val,
  // device side
  input  wire logic                   strobe_seen,
  input  wire logic [CMBL_ADDR_W-1:0] dev_addr,
  input  wire logic                   line_oe,
  input  wire logic                   sub_oe,
  // controller outputs
  output logic                        line_addr_latch_en,
  output logic                        subline_addr_latch_en,
  output logic                        line_addr_out_en_n,
  output logic                        subline_addr_out_en_n,
  output logic                        next_addr_request,
  output logic                        cycle_done,
  output logic                        snoop_request_strobe,
  output logic                        snoop_clock,
  output logic      [CMBL_ADDR_W-1:0] pin
);
  logic [2:0]             cnt;
  logic [CMBL_ADDR_W-1:0] last;
  // gating, cycle handshake, device floated before snoop strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      line_addr_latch_en    <= 1'b1;
      subline_addr_latch_en <= 1'b1;
      line_addr_out_en_n    <= 1'b1;
      subline_addr_out_en_n <= 1'b1;
      {next_addr_request, cycle_done, snoop_request_strobe, snoop_clock} <= 4'h0;
      cnt                   <= 3'h0;
      last                  <= 30'h0;
    end else begin
      line_addr_latch_en    <= ~hold_latch;
      subline_addr_latch_en <= ~hold_latch;
      line_addr_out_en_n    <= float_out | snoop_req;
      subline_addr_out_en_n <= float_out | snoop_req;
      snoop_request_strobe  <= snoop_req & line_addr_out_en_n;
      snoop_clock           <= snoop_req & ~snoop_clock;  // runs only in snoops
      next_addr_request     <= cnt == 3'h2;
      cycle_done            <= cnt == 3'h1;
      cnt                   <= strobe_seen ? (slow ? 3'h4 : 3'h1) :
                               (cnt != 3'h0) ? cnt - 3'h1 : cnt;
      last                  <= pin;
    end
  end
  // wire level: device when driving, else snoop address, else inverted
  always_comb begin
    pin = snoop_request_strobe ? snoop_val : ~last;
    if (line_oe) pin[CMBL_ADDR_W-1:CMBL_SEL_W] = dev_addr[CMBL_ADDR_W-1:CMBL_SEL_W];
    if (sub_oe) pin[CMBL_SEL_W-1:0] = dev_addr[CMBL_SEL_W-1:0];
  end
endmodule // cmbl_mbc_model

// ===== sim/testbench.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); \
  end \
end
// ============================================================
// bench top: clock, reset, scenarios and verdict
module testbench import cmbl_pkg::*;;
  logic                   clk, arst_n, cpu_addr_strobe, cpu_lock, cpu_split_cycle, cpu_write;
  logic                   cache_lock_mode, bus_cycle_req, snoop_out_req, snoop_window_end;
  logic                   line_owned, next_addr_request, cycle_done, line_addr_latch_en;
  logic                   subline_addr_latch_en, line_addr_out_en_n, subline_addr_out_en_n;
  logic                   snoop_request_strobe, snoop_clock, mem_cfg_addr_oe, mem_sel_addr_oe;
  logic                   mem_set_addr_oe, mem_tag_addr_oe, mem_lock_request, mem_addr_parity;
  logic                   mem_cycle_addr_strobe, snoop_cycle_strobe_out, addr_may_change;
  logic                   snoop_addr_valid, hold_latch, float_out, slow, snoop_req;
  logic                   strobe_seen, line_oe, sub_oe;
  logic [3:0]             oe4;
  logic [CMBL_ADDR_W-1:0] cycle_addr, snoop_addr, snoop_val, dev_addr, pin;
  logic [CMBL_CFG_W-1:0]  mem_cfg_addr_in, mem_cfg_addr_out;
  logic [CMBL_SEL_W-1:0]  mem_sel_addr_in, mem_sel_addr_out;
  logic [CMBL_SET_W-1:0]  mem_set_addr_in, mem_set_addr_out;
  logic [CMBL_TAG_W-1:0]  mem_tag_addr_in, mem_tag_addr_out;
  cmbl_line_state_t       cpu_line_state;
  cmbl_snoop_mode_t       snoop_mode;
  int                     miscompares, samples_checked;
  // wire level split into pin inputs, device outputs gathered
  assign {mem_tag_addr_in, mem_set_addr_in, mem_cfg_addr_in, mem_sel_addr_in} = pin;
  assign dev_addr = {mem_tag_addr_out, mem_set_addr_out, mem_cfg_addr_out, mem_sel_addr_out};
  assign oe4 = {mem_tag_addr_oe, mem_set_addr_oe, mem_cfg_addr_oe, mem_sel_addr_oe};
  assign line_oe = mem_set_addr_oe;
  assign sub_oe = mem_sel_addr_oe;
  assign strobe_seen = mem_cycle_addr_strobe | snoop_cycle_strobe_out;
  cmbl_lock_addr dut_u (.*);
  cmbl_mbc_model mbc_u (.*);
  // 250 MHz clock
  initial clk = 1'b0;
  always #2 clk = ~clk;
  // ============================================================
  // shared tasks
  task automatic tick(input int n = 1);
    repeat (n) @(negedge clk);
  endtask
  // one processor cycle with lock attributes; bus opens a memory cycle
  task automatic req(input logic lk, sp, bus, input cmbl_line_state_t st,
                     input logic [CMBL_ADDR_W-1:0] a);
    cpu_addr_strobe = 1'b1;
    cpu_lock = lk;
    cpu_split_cycle = sp;
    cpu_line_state = st;
    bus_cycle_req = bus;
    cycle_addr = a;
    tick();
    cpu_addr_strobe = 1'b0;
    bus_cycle_req = 1'b0;
  endtask
  // drop lock, then leave the idle clock
  task automatic unlock();
    cpu_lock = 1'b0;
    tick(2);
  endtask
  task automatic stop_test();
    $display("compares %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ============================================================
  // scenarios
  task automatic t_split();
    cache_lock_mode = 1'b0;
    req(1'b1, 1'b1, 1'b1, CMBL_LS_S, 30'h0123_4567);
    `CHK(mem_cycle_addr_strobe, 1'b1)
    `CHK(mem_lock_request, 1'b1)
    tick(2);
    cpu_write = 1'b1;
    req(1'b1, 1'b1, 1'b1, CMBL_LS_S, 30'h0123_4567);
    `CHK(mem_lock_request, 1'b1)
    cpu_write = 1'b0;
    cpu_lock = 1'b0;
    `CHK(mem_lock_request, 1'b1)
    tick();
    `CHK(mem_lock_request, 1'b0)
    tick();
    req(1'b1, 1'b0, 1'b1, CMBL_LS_S, 30'h0);
    `CHK(mem_lock_request, 1'b0)
    unlock();
    $display("split lock test done");
  endtask
  task automatic t_nonsplit();
    cache_lock_mode = 1'b1;
    for (int s = 2; s < 4; s++) begin
      req(1'b1, 1'b0, 1'b0, cmbl_line_state_t'(s), 30'h0);
      `CHK({mem_cycle_addr_strobe, mem_lock_request}, 2'h0)
      unlock();
    end
    req(1'b1, 1'b0, 1'b1, CMBL_LS_S, 30'h0);
    `CHK(mem_lock_request, 1'b1)
    tick(3);
    `CHK(mem_lock_request, 1'b1)
    unlock();
    `CHK(mem_lock_request, 1'b0)
    req(1'b1, 1'b0, 1'b1, CMBL_LS_I, 30'h0);
    tick();
    cpu_write = 1'b1;
    req(1'b0, 1'b0, 1'b1, CMBL_LS_I, 30'h0);
    cpu_write = 1'b0;
    `CHK({mem_cycle_addr_strobe, mem_lock_request}, 2'h3)
    unlock();
    `CHK(mem_lock_request, 1'b0)
    req(1'b1, 1'b0, 1'b1, CMBL_LS_I, 30'h0);
    snoop_window_end = 1'b1;
    line_owned = 1'b1;
    tick();
    snoop_window_end = 1'b0;
    line_owned = 1'b0;
    `CHK(mem_lock_request, 1'b1)
    tick(2);
    `CHK(mem_lock_request, 1'b0)
    unlock();
    $display("non-split lock test done");
  endtask
  task automatic t_addr();
    slow = 1'b1;
    req(1'b0, 1'b0, 1'b1, CMBL_LS_I, 30'h2d3c_4b5a);
    `CHK(dev_addr, 30'h2d3c_4b5a)
    `CHK(oe4, 4'hf)
    `CHK(mem_addr_parity, ^30'h2d3c_4b5a)
    for (int i = 0; i < 8 && addr_may_change !== 1'b1; i++)
      tick();
    `CHK(addr_may_change, 1'b1)
    slow = 1'b0;
    hold_latch = 1'b1;
    tick();
    req(1'b0, 1'b0, 1'b1, CMBL_LS_I, 30'h1234_5678);
    `CHK(dev_addr, 30'h2d3c_4b5a)
    hold_latch = 1'b0;
    tick(3);
    `CHK(dev_addr, 30'h1234_5678)
    float_out = 1'b1;
    tick(2);
    `CHK(oe4, 4'h0)
    req(1'b0, 1'b0, 1'b1, CMBL_LS_I, 30'h3a5a_0f0f);
    `CHK(oe4, 4'h0)
    float_out = 1'b0;
    tick(2);
    `CHK({oe4, dev_addr}, {4'hf, 30'h3a5a_0f0f})
    snoop_out_req = 1'b1;
    cycle_addr = 30'h0f0f_1234;
    tick();
    snoop_out_req = 1'b0;
    `CHK({snoop_cycle_strobe_out, dev_addr}, {1'b1, 30'h0f0f_1234})
    $display("address test done");
  endtask
  task automatic t_snoop();
    int n;
    logic [CMBL_ADDR_W-1:0] s;
    for (int m = 0; m < 4; m++) begin
      snoop_mode = cmbl_snoop_mode_t'(m);
      s = 30'h1e2d_3c4b ^ CMBL_ADDR_W'(m);
      snoop_val = s;
      n = 0;
      for (int k = 0; k < 16; k++) begin
        snoop_req = (k >= 3) && (k < 11);
        tick();
        if (snoop_addr_valid === 1'b1) begin
          n++;
          `CHK(snoop_addr, s)
        end
      end
      `CHK(n, int'(m < 3))
    end
    $display("snoop test done");
  endtask
  // ============================================================
  // main sequence
  initial begin
    {cpu_addr_strobe, cpu_lock, cpu_split_cycle, cpu_write, cache_lock_mode} = 5'h0;
    {bus_cycle_req, snoop_out_req, snoop_window_end, line_owned} = 4'h0;
    {hold_latch, float_out, slow, snoop_req} = 4'h0;
    {cycle_addr, snoop_val} = 60'h0;
    cpu_line_state = CMBL_LS_I;
    snoop_mode = CMBL_SNP_SYNC;
    arst_n = 1'b0;
    tick(20);
    `CHK(mem_lock_request, 1'b0)
    arst_n = 1'b1;
    tick(2);
    `CHK(mem_lock_request, 1'b0)
    t_split();
    t_nonsplit();
    t_addr();
    t_snoop();
    stop_test();
  end
  // watchdog
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    stop_test();
  end
endmodule // testbench
